/* File: common/rx_slot_pkg.sv */
// constants for the receive slot mask and serial receiver block
// assumes a 32-bit APB register port and a byte-addressed map
package rx_slot_pkg;
    localparam logic [7:0]  OFS_RX_DATA    = 8'h08;
    localparam logic [7:0]  OFS_MAIN       = 8'h10;
    localparam logic [7:0]  OFS_TX_CFG     = 8'h1C;
    localparam logic [7:0]  OFS_RX_CFG     = 8'h20;
    localparam logic [7:0]  OFS_TX_CLK     = 8'h24;
    localparam logic [7:0]  OFS_STATUS     = 8'h28;
    localparam logic [7:0]  OFS_RX_MASK    = 8'h4C;
    // main_control fields
    localparam int          MC_ENABLE      = 0;
    localparam int          MC_TX_ENABLE   = 1;
    localparam int          MC_RX_ENABLE   = 2;
    localparam logic [31:0] MC_WMASK       = 32'h0000026F;
    // receive_config / transmit_config fields, bits 0-7 and 9
    localparam int          CF_FS_INVERT   = 2;
    localparam int          CF_CLK_POL     = 3;
    localparam int          CF_SHIFT_ORDER = 4;
    localparam logic [31:0] CF_WMASK       = 32'h000002FF;
    // transmit_clock_control word_length field
    localparam int          WL_LSB         = 13;
    localparam logic [31:0] TC_WMASK       = 32'h0001E000;
    // status fields
    localparam int          ST_OVERRUN     = 0;
    localparam int          ST_COUNT_LSB   = 4;
    localparam int          ST_SLOT_LSB    = 16;
    localparam logic [31:0] RST_ZERO       = 32'h00000000;
    localparam int          FIFO_DEPTH     = 16;
endpackage

/* File: hdl/rx_slot_rx.sv */
// serial receiver with per-slot receive mask, soft reset and APB registers
// assumes link pins are asynchronous to pclk and slower than pclk/4
//
// What this block does
// - 32-bit mask, set bit ignores that slot
// - mask changes apply from next slot
// - power-on reset clears interface enable
// - clearing enable resets all status bits
// - soft reset keeps all control bits
`timescale 1ns/1ps
`default_nettype none

module rx_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         clk,      // clock
    input  wire logic         rst_n,    // async reset
    input  wire logic         ce,       // clock enable
    input  wire logic         flush,    // empties the queue
    input  wire logic         in_valid, // write request
    output logic              in_ready, // room for one word
    input  wire logic [W-1:0] in_data,  // write word
    output logic              out_valid,// word available
    input  wire logic         out_ready,// pop
    output logic [W-1:0]      out_data, // head word
    output logic [$clog2(D):0] count    // words held
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          wr;
    logic          rd;

    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign count     = cnt_q;
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (ce && wr) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (flush) begin
                wp_q  <= '0;
                rp_q  <= '0;
                cnt_q <= '0;
            end else begin
                if (wr) wp_q <= wp_q + 1'b1;
                if (rd) rp_q <= rp_q + 1'b1;
                cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
            end
        end
    end
endmodule

module rx_slot_rx (
    input  wire logic        pclk,      // 40 MHz clock
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        ce,        // clock enable, freezes all state
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB access phase
    input  wire logic        pwrite,    // APB write
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic [31:0]      prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error on unmapped address
    input  wire logic        link_bclk, // serial bit clock pin
    input  wire logic        link_fsync,// frame sync pin
    input  wire logic        link_rxd   // serial receive data pin
);
    logic [31:0] main_q, rxcfg_q, txcfg_q, txclk_q, mask_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q, rd_valid_q;
    logic [2:0]  bclk_s_q, fs_s_q, rxd_s_q;
    logic        fs_prev_q, mask_cur_q, push_q, ovr_q;
    logic [4:0]  bit_q, slot_q;
    logic [31:0] shift_q, word_q;
    logic        acc, done, wr_done, en, run, edge_hit, fs_act, bit_in;
    logic        frame_start, word_done, in_ready, out_valid, pop;
    logic [31:0] shift_d, shift_base, out_data, rd_mux;
    logic [4:0]  last_bit;
    logic [4:0]  fcount;
    logic        hit;

    assign acc     = psel && penable;
    assign done    = acc && pready_q;
    assign wr_done = done && pwrite;
    assign en      = main_q[rx_slot_pkg::MC_ENABLE];
    assign run     = en && main_q[rx_slot_pkg::MC_RX_ENABLE];
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    always_comb begin
        hit    = 1'b1;
        rd_mux = rx_slot_pkg::RST_ZERO;
        case (paddr)
            rx_slot_pkg::OFS_RX_DATA: rd_mux = out_valid ? out_data : rx_slot_pkg::RST_ZERO;
            rx_slot_pkg::OFS_MAIN:    rd_mux = main_q;
            rx_slot_pkg::OFS_TX_CFG:  rd_mux = txcfg_q;
            rx_slot_pkg::OFS_RX_CFG:  rd_mux = rxcfg_q;
            rx_slot_pkg::OFS_TX_CLK:  rd_mux = txclk_q;
            rx_slot_pkg::OFS_RX_MASK: rd_mux = mask_q;
            rx_slot_pkg::OFS_STATUS: begin
                rd_mux[rx_slot_pkg::ST_OVERRUN] = ovr_q;
                rd_mux[rx_slot_pkg::ST_COUNT_LSB +: 5] = fcount;
                rd_mux[rx_slot_pkg::ST_SLOT_LSB +: 5] = slot_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // one wait state: data and error are registered while pready is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= rx_slot_pkg::RST_ZERO;
            pslverr_q <= 1'b0;
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            pready_q <= acc && !pready_q;
            if (acc && !pready_q) begin
                prdata_q  <= pwrite ? rx_slot_pkg::RST_ZERO : rd_mux;
                pslverr_q <= !hit;
                rd_valid_q <= out_valid;
            end
        end
    end

    // control bits see only presetn; the soft reset leaves them alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_q  <= rx_slot_pkg::RST_ZERO;
            rxcfg_q <= rx_slot_pkg::RST_ZERO;
            txcfg_q <= rx_slot_pkg::RST_ZERO;
            txclk_q <= rx_slot_pkg::RST_ZERO;
            mask_q  <= rx_slot_pkg::RST_ZERO;
        end else if (ce && wr_done) begin
            case (paddr)
                rx_slot_pkg::OFS_MAIN:    main_q  <= pwdata & rx_slot_pkg::MC_WMASK;
                rx_slot_pkg::OFS_RX_CFG:  rxcfg_q <= pwdata & rx_slot_pkg::CF_WMASK;
                rx_slot_pkg::OFS_TX_CFG:  txcfg_q <= pwdata & rx_slot_pkg::CF_WMASK;
                rx_slot_pkg::OFS_TX_CLK:  txclk_q <= pwdata & rx_slot_pkg::TC_WMASK;
                rx_slot_pkg::OFS_RX_MASK: mask_q  <= pwdata;
                default: ;
            endcase
        end
    end

    // two flops per pin; the third only feeds edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_s_q <= '0;
            fs_s_q   <= '0;
            rxd_s_q  <= '0;
        end else if (ce) begin
            bclk_s_q <= {bclk_s_q[1:0], link_bclk};
            fs_s_q   <= {fs_s_q[1:0], link_fsync};
            rxd_s_q  <= {rxd_s_q[1:0], link_rxd};
        end
    end

    assign edge_hit = rxcfg_q[rx_slot_pkg::CF_CLK_POL] ? (bclk_s_q[2] && !bclk_s_q[1])
                                                       : (bclk_s_q[1] && !bclk_s_q[2]);
    assign fs_act   = fs_s_q[1] ^ rxcfg_q[rx_slot_pkg::CF_FS_INVERT];
    assign bit_in   = rxd_s_q[1];
    // each slot starts from zero, so no bit of a neighbouring, maybe masked, slot leaks into its word
    assign shift_base = (frame_start || bit_q == 5'h00) ? rx_slot_pkg::RST_ZERO : shift_q;
    assign shift_d  = rxcfg_q[rx_slot_pkg::CF_SHIFT_ORDER] ? {bit_in, shift_base[31:1]}
                                                           : {shift_base[30:0], bit_in};
    // slot length is 2*(word_length+1) bits, 2 to 32
    assign last_bit    = {txclk_q[rx_slot_pkg::WL_LSB +: 4], 1'b1};
    assign frame_start = run && edge_hit && fs_act && !fs_prev_q;
    assign word_done   = run && edge_hit && !frame_start && (bit_q == last_bit);

    // clearing enable flushes all receive status back to its reset state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_prev_q  <= 1'b0;
            bit_q      <= '0;
            slot_q     <= '0;
            shift_q    <= rx_slot_pkg::RST_ZERO;
            word_q     <= rx_slot_pkg::RST_ZERO;
            mask_cur_q <= 1'b0;
            push_q     <= 1'b0;
        end else if (ce) begin
            push_q <= 1'b0;
            if (!en) begin
                fs_prev_q  <= 1'b0;
                bit_q      <= '0;
                slot_q     <= '0;
                shift_q    <= rx_slot_pkg::RST_ZERO;
                mask_cur_q <= 1'b0;
            end else if (run && edge_hit) begin
                fs_prev_q <= fs_act;
                shift_q   <= shift_d;
                if (frame_start) begin
                    slot_q     <= '0;
                    bit_q      <= 5'h01;
                    mask_cur_q <= mask_q[0];
                end else if (word_done) begin
                    word_q     <= shift_d;
                    push_q     <= !mask_cur_q;
                    slot_q     <= slot_q + 5'h01;
                    bit_q      <= '0;
                    mask_cur_q <= mask_q[slot_q + 5'h01];
                end else begin
                    bit_q <= bit_q + 5'h01;
                end
            end
        end
    end

    // a word that finds the queue full is lost and flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_q <= 1'b0;
        end else if (ce) begin
            if (!en) ovr_q <= 1'b0;
            else if (push_q && !in_ready) ovr_q <= 1'b1;
            else if (wr_done && paddr == rx_slot_pkg::OFS_STATUS && pwdata[rx_slot_pkg::ST_OVERRUN]) ovr_q <= 1'b0;
        end
    end

    // pop only a word that was shown in prdata, else one pushed during the wait state is lost
    assign pop = ce && done && !pwrite && paddr == rx_slot_pkg::OFS_RX_DATA && rd_valid_q;

    rx_fifo #(.W(32), .D(rx_slot_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .ce        (ce),
        .flush     (!en),
        .in_valid  (push_q),
        .in_ready  (in_ready),
        .in_data   (word_q),
        .out_valid (out_valid),
        .out_ready (pop),
        .out_data  (out_data),
        .count     (fcount)
    );

    logic boot_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) boot_q <= 1'b0;
        else if (ce)  boot_q <= 1'b1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    AST_POR_DISABLED: assert property (!boot_q |-> !en)
        else $error("enable set straight after reset");
    AST_MASK_WRITE: assert property (wr_done && paddr == rx_slot_pkg::OFS_RX_MASK |=> mask_q == $past(pwdata))
        else $error("mask write lost");
    AST_MASKED_DROP: assert property (word_done && mask_cur_q |=> !push_q)
        else $error("masked slot captured");
    AST_VALID_PUSH: assert property (word_done && !mask_cur_q |=> push_q && word_q == $past(shift_d))
        else $error("valid slot not captured");
    AST_MASK_HELD: assert property (en && !frame_start && !word_done |=> $stable(mask_cur_q))
        else $error("mask applied inside a slot");
    AST_SOFT_CLEAR: assert property (!en |=> !ovr_q && slot_q == 5'h00 && fcount == 5'h00)
        else $error("status survived soft reset");
    AST_CTRL_KEPT: assert property (!en && !wr_done |=> $stable(main_q) && $stable(rxcfg_q) && $stable(mask_q))
        else $error("control changed in soft reset");
    AST_IDLE_NO_CAPTURE: assert property (!run |=> !push_q ##1 !push_q || run)
        else $error("capture while receiver off");
    AST_OVERRUN: assert property (en && push_q && !in_ready |=> ovr_q)
        else $error("overrun not flagged");

    COV_MASKED: cover property (word_done && mask_cur_q);
    COV_PUSH: cover property (push_q && in_ready);
    COV_OVERRUN: cover property ($rose(ovr_q));
    COV_SOFT: cover property ($fell(en) && fcount != 5'h00);
endmodule

`default_nettype wire

/* File: verification/codec_model.sv */
// behavioural serial audio source driving the receive link pins
// assumes the receiver samples on the rising bit clock edge, msb first
`timescale 1ns/1ps
`default_nettype none

module codec_model #(
    parameter int HALF_NS = 100
) (
    output logic link_bclk,  // bit clock, still between frames
    output logic link_fsync, // frame sync, high during the first bit
    output logic link_rxd    // serial data
);
    initial begin
        link_bclk  = 1'b0;
        link_fsync = 1'b0;
        link_rxd   = 1'b0;
    end

    // one frame of four 8-bit slots, slot 0 in the top byte; normal framing, never slave i2s
    task automatic send_frame(input logic [31:0] words);
        int i;
        #7; // keeps bit clock edges off the pclk edges
        for (i = 0; i < 32; i++) begin
            link_rxd   = words[31-i];
            link_fsync = (i == 0);
            #(HALF_NS) link_bclk = 1'b1;
            #(HALF_NS) link_bclk = 1'b0;
        end
        link_fsync = 1'b0;
        link_rxd   = ~link_rxd; // no pull on the data line: a released line shows no stale bit
    endtask
endmodule

`default_nettype wire

/* File: verification/serial_audio_rx_slot_mask_and_init_test.sv */
// self-checking bench for the receive slot mask, soft reset and init order
// assumes codec_model on the link pins and a one-wait-state apb slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end

module serial_audio_rx_slot_mask_and_init_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        link_bclk, link_fsync, link_rxd;
    int          n_errors, compares;
    localparam logic [31:0] FRAME = 32'hA53C0FF0;

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    rx_slot_rx u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_bclk(link_bclk), .link_fsync(link_fsync), .link_rxd(link_rxd));
    codec_model u_codec (.link_bclk(link_bclk), .link_fsync(link_fsync), .link_rxd(link_rxd));

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        `CHK("access cycles", 2, n)
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(nm, e, rd)
    endtask

    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #500000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        int k;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        n_errors = 0;
        compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("mask reset", rx_slot_pkg::OFS_RX_MASK, 32'h00000000);
        rd_chk("main reset", rx_slot_pkg::OFS_MAIN, 32'h00000000);
        apb(1'b0, 8'h04, 32'h00000000);
        `CHK("unmapped error", 1'b1, err)
        done("reset");
        wr(rx_slot_pkg::OFS_MAIN, 32'h00000000);
        wr(rx_slot_pkg::OFS_MAIN, 32'h00000008);
        wr(rx_slot_pkg::OFS_TX_CLK, 32'h00006000);
        wr(rx_slot_pkg::OFS_RX_MASK, 32'h0000000A);
        rd_chk("mask rw", rx_slot_pkg::OFS_RX_MASK, 32'h0000000A);
        wr(rx_slot_pkg::OFS_MAIN, 32'h00000009);
        wr(rx_slot_pkg::OFS_MAIN, 32'h0000000F);
        rd_chk("main on", rx_slot_pkg::OFS_MAIN, 32'h0000000F);
        u_codec.send_frame(FRAME);
        settle();
        rd_chk("slot 0", rx_slot_pkg::OFS_RX_DATA, 32'h000000A5);
        rd_chk("slot 2", rx_slot_pkg::OFS_RX_DATA, 32'h0000000F);
        rd_chk("masked empty", rx_slot_pkg::OFS_RX_DATA, 32'h00000000);
        done("mask");
        // the write lands in the middle of slot 0
        fork
            u_codec.send_frame(FRAME);
            begin
                #800;
                wr(rx_slot_pkg::OFS_RX_MASK, 32'h0000000F);
            end
        join
        settle();
        rd_chk("slot 0 kept", rx_slot_pkg::OFS_RX_DATA, 32'h000000A5);
        rd_chk("later masked", rx_slot_pkg::OFS_RX_DATA, 32'h00000000);
        done("mid-slot mask write");
        wr(rx_slot_pkg::OFS_RX_MASK, 32'h00000000);
        repeat (5) u_codec.send_frame(FRAME);
        settle();
        apb(1'b0, rx_slot_pkg::OFS_STATUS, 32'h00000000);
        `CHK("full status", 32'h00000101, rd & 32'h000003F1)
        wr(rx_slot_pkg::OFS_STATUS, 32'h00000001);
        apb(1'b0, rx_slot_pkg::OFS_STATUS, 32'h00000000);
        `CHK("overrun cleared", 32'h00000100, rd & 32'h000003F1)
        for (k = 0; k < 16; k++) begin
            rd_chk("drained", rx_slot_pkg::OFS_RX_DATA, {24'h000000, FRAME[31-8*(k%4) -: 8]});
        end
        rd_chk("drained empty", rx_slot_pkg::OFS_RX_DATA, 32'h00000000);
        done("fill and drain");
        wr(rx_slot_pkg::OFS_MAIN, 32'h0000000E);
        rd_chk("status soft reset", rx_slot_pkg::OFS_STATUS, 32'h00000000);
        rd_chk("main kept", rx_slot_pkg::OFS_MAIN, 32'h0000000E);
        rd_chk("length kept", rx_slot_pkg::OFS_TX_CLK, 32'h00006000);
        done("soft reset");
        tally_and_finish();
    end
endmodule

`default_nettype wire
